// ==== design/stcr_pkg.sv ====
package stcr_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] OFS_CFG3 = 8'h00;
  localparam logic [7:0] OFS_CFG4 = 8'h04;
  localparam logic [7:0] OFS_CFG5 = 8'h08;
  localparam logic [7:0] OFS_SDR = 8'h0c;
  localparam logic [7:0] OFS_PWR = 8'h10;
  localparam logic [7:0] OFS_MUX = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ddr2 config 3 fields
  localparam int C3_BRST = 31;
  localparam int C3_PDIR = 30;
  localparam int C3_PUPD = 29;
  localparam int C3_TRP0 = 28;
  localparam int C3_TWR = 23;
  localparam int C3_TRFC = 18;
  localparam int C3_RD = 16;
  localparam int C3_BINC = 8;
  localparam int C3_BUPD = 0;
  localparam logic [1:0] RD_LO_RST = 2'h1;
  // ddr2 config 4 fields
  localparam int C4_CINC = 28;
  localparam int C4_CUPD = 24;
  localparam int C4_RDH = 22;
  localparam int C4_REG = 21;
  localparam int C4_TRTP = 13;
  localparam int C4_TCL = 9;
  localparam int C4_B8 = 8;
  localparam int C4_DQS = 0;
  // ddr2 config 5 fields
  localparam int C5_TRP = 28;
  localparam int C5_TRFC = 18;
  localparam int C5_ODT = 16;
  localparam int C5_DS = 15;
  localparam int C5_TRCD = 8;
  localparam int C5_TRAS = 0;
  // sdr config fields
  localparam int SD_REF = 31;
  localparam int SD_TRP = 30;
  localparam int SD_TRFC = 27;
  localparam int SD_CAS = 26;
  localparam int SD_BANK = 23;
  localparam int SD_COL = 21;
  localparam int SD_CMD = 18;
  localparam int SD_PAGE = 17;
  localparam int SD_MS = 16;
  localparam int SD_D64 = 15;
  localparam int SD_RLD = 0;
  // sdr power-saving fields
  localparam int PW_ME = 31;
  localparam int PW_CE = 30;
  localparam int PW_TXSR = 20;
  localparam int PW_PMODE = 16;
  localparam int PW_DS = 5;
  localparam int PW_TCSR = 3;
  localparam int PW_PARTIAL_REFRESH_AREA = 0;
  // mux config fields
  localparam int MX_DWTH = 16;
  localparam int MX_BEID = 12;
  localparam int MX_CTL = 0;
  localparam logic [2:0] MUX_DWTH_VAL = 3'h3;
  localparam logic [3:0] MUX_BEID_VAL = 4'h0;
  localparam logic D64_VAL = 1'b1;
  // fixed timing offsets, in memory clock cycles, and the idle command and power-mode codes
  localparam logic [3:0] ADD_TWO = 4'h2;
  localparam logic [8:0] ADD_THREE = 9'h003;
  localparam logic [2:0] CMD_NONE = 3'h0;
  localparam logic [2:0] PM_NONE = 3'h0;
endpackage : stcr_pkg

// ==== design/stcr_regs.sv ====
`timescale 1ns/1ns
module stcr_regs
  import stcr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic mobile_support,
  input wire logic sdr_cmd_done,
  output logic clock_phase_step,
  output logic clock_phase_inc,
  output logic [11:0] lane_delay_update,
  output logic [11:0] lane_delay_inc,
  output logic byte_delay_reset,
  output logic [3:0] read_delay_cycles,
  output logic ctrl_extra_latency,
  output logic [1:0] trtp_cycles,
  output logic [3:0] trp_cycles,
  output logic [8:0] trfc_cycles,
  output logic [3:0] trcd_cycles,
  output logic [5:0] tras_cycles,
  output logic [4:0] twr_field,
  output logic [1:0] cas_field,
  output logic eight_banks,
  output logic [7:0] dqs_gate_offset,
  output logic odt_enable,
  output logic [1:0] odt_sel,
  output logic drive_strength_sel,
  output logic [1:0] sdr_trp_cycles,
  output logic [4:0] sdr_trfc_cycles,
  output logic [1:0] sdr_cas_cycles,
  output logic [1:0] sdr_trcd_cycles,
  output logic sdr_page_burst,
  output logic sdr_refresh_en,
  output logic [14:0] sdr_refresh_load,
  output logic [2:0] sdr_cmd,
  output logic sdr_cmd_valid,
  output logic mem_cke,
  output logic [2:0] power_mode,
  output logic [2:0] partial_refresh_area,
  output logic [7:0] lane_mux_ctl
);

  typedef struct packed {
    logic aw_have;
    logic [7:0] awaddr;
    logic w_have;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [4:0] twr;
    logic [1:0] rd_lo;
    logic [1:0] rd_hi;
    logic reg_mem;
    logic trtp;
    logic [1:0] tcl;
    logic b8;
    logic [7:0] dqs;
    logic [2:0] trp;
    logic [7:0] trfc;
    logic [1:0] odt;
    logic ds;
    logic [2:0] trcd;
    logic [4:0] tras;
    logic sd_ref;
    logic sd_trp;
    logic [2:0] sd_trfc;
    logic sd_cas;
    logic [2:0] sd_bank;
    logic [1:0] sd_col;
    logic [2:0] sd_cmd;
    logic sd_page;
    logic [14:0] sd_rld;
    logic pw_ce;
    logic [3:0] pw_txsr;
    logic [2:0] pw_mode;
    logic [1:0] pw_ds;
    logic [1:0] pw_tcsr;
    logic [2:0] pw_partial_refresh_area;
    logic [7:0] mux;
    logic ph_step;
    logic ph_inc;
    logic [11:0] ln_upd;
    logic [11:0] ln_inc;
    logic bd_rst;
    logic [3:0] rd_dly;
    logic [3:0] o_trp;
    logic [8:0] o_trfc;
    logic [3:0] o_trcd;
    logic [5:0] o_tras;
    logic [1:0] o_sd_trfc_hi;
  } stcr_state_t;

  stcr_state_t s_q;
  stcr_state_t s_d;

  // current register image, used for read-back and byte-merged writes
  function automatic logic [31:0] stcr_word(input stcr_state_t s, input logic [7:0] a,
                                            input logic ms);
    logic [31:0] w;
    w = 32'h0;
    unique case (a)
      OFS_CFG3: begin
        w[C3_TRP0] = s.trp[0];
        w[C3_TWR +: 5] = s.twr;
        w[C3_TRFC +: 5] = s.trfc[4:0];
        w[C3_RD +: 2] = s.rd_lo;
      end
      OFS_CFG4: begin
        w[C4_RDH +: 2] = s.rd_hi;
        w[C4_REG] = s.reg_mem;
        w[C4_TRTP] = s.trtp;
        w[C4_TCL +: 2] = s.tcl;
        w[C4_B8] = s.b8;
        w[C4_DQS +: 8] = s.dqs;
      end
      OFS_CFG5: begin
        w[C5_TRP +: 3] = s.trp;
        w[C5_TRFC +: 8] = s.trfc;
        w[C5_ODT +: 2] = s.odt;
        w[C5_DS] = s.ds;
        w[C5_TRCD +: 3] = s.trcd;
        w[C5_TRAS +: 5] = s.tras;
      end
      OFS_SDR: begin
        w[SD_REF] = s.sd_ref;
        w[SD_TRP] = s.sd_trp;
        w[SD_TRFC +: 3] = s.sd_trfc;
        w[SD_CAS] = s.sd_cas;
        w[SD_BANK +: 3] = s.sd_bank;
        w[SD_COL +: 2] = s.sd_col;
        w[SD_CMD +: 3] = s.sd_cmd;
        w[SD_PAGE] = s.sd_page;
        w[SD_MS] = ms;
        w[SD_D64] = D64_VAL;
        w[SD_RLD +: 15] = s.sd_rld;
      end
      OFS_PWR: begin
        w[PW_ME] = ms;
        w[PW_CE] = s.pw_ce;
        w[PW_TXSR +: 4] = s.pw_txsr;
        w[PW_PMODE +: 3] = s.pw_mode;
        w[PW_DS +: 2] = s.pw_ds;
        w[PW_TCSR +: 2] = s.pw_tcsr;
        w[PW_PARTIAL_REFRESH_AREA +: 3] = s.pw_partial_refresh_area;
      end
      OFS_MUX: begin
        w[MX_DWTH +: 3] = MUX_DWTH_VAL;
        w[MX_BEID +: 4] = MUX_BEID_VAL;
        w[MX_CTL +: 8] = s.mux;
      end
      default: w = 32'h0;
    endcase
    return w;
  endfunction : stcr_word

  function automatic logic stcr_hit(input logic [7:0] a);
    return a == OFS_CFG3 || a == OFS_CFG4 || a == OFS_CFG5 || a == OFS_SDR ||
           a == OFS_PWR || a == OFS_MUX;
  endfunction : stcr_hit

  logic [31:0] wm;
  logic [31:0] nw;
  logic wr_go;

  always_comb begin
    s_d = s_q;
    wm = {{8{s_q.wstrb[3]}}, {8{s_q.wstrb[2]}}, {8{s_q.wstrb[1]}}, {8{s_q.wstrb[0]}}};
    nw = (stcr_word(s_q, s_q.awaddr, mobile_support) & ~wm) | (s_q.wdata & wm);
    wr_go = s_q.aw_have && s_q.w_have;
    // update strobes last one cycle
    s_d.ph_step = 1'b0;
    s_d.ln_upd = 12'h000;
    s_d.bd_rst = 1'b0;
    // write address and data are taken independently
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_have = 1'b1;
      s_d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_have = 1'b1;
      s_d.wdata = s_axi_wdata;
      s_d.wstrb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    // command completion clears the field; a new write below overrides it
    if (sdr_cmd_done) begin
      s_d.sd_cmd = CMD_NONE;
    end
    if (wr_go) begin
      s_d.aw_have = 1'b0;
      s_d.w_have = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = stcr_hit(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      unique case (s_q.awaddr)
        OFS_CFG3: begin
          s_d.bd_rst = nw[C3_BRST] && s_q.wstrb[3];
          s_d.ph_step = nw[C3_PUPD] && s_q.wstrb[3];
          if (s_q.wstrb[3]) begin
            s_d.ph_inc = nw[C3_PDIR];
          end
          s_d.trp[0] = nw[C3_TRP0];
          s_d.twr = nw[C3_TWR +: 5];
          s_d.trfc[4:0] = nw[C3_TRFC +: 5];
          s_d.rd_lo = nw[C3_RD +: 2];
          s_d.ln_upd[7:0] = s_q.wdata[C3_BUPD +: 8] & wm[C3_BUPD +: 8];
          if (s_q.wstrb[1]) begin
            s_d.ln_inc[7:0] = s_q.wdata[C3_BINC +: 8];
          end
        end
        OFS_CFG4: begin
          s_d.ln_upd[11:8] = s_q.wdata[C4_CUPD +: 4] & wm[C4_CUPD +: 4];
          if (s_q.wstrb[3]) begin
            s_d.ln_inc[11:8] = s_q.wdata[C4_CINC +: 4];
          end
          s_d.rd_hi = nw[C4_RDH +: 2];
          s_d.reg_mem = nw[C4_REG];
          s_d.trtp = nw[C4_TRTP];
          s_d.tcl = nw[C4_TCL +: 2];
          s_d.b8 = nw[C4_B8];
          s_d.dqs = nw[C4_DQS +: 8];
        end
        OFS_CFG5: begin
          s_d.trp = nw[C5_TRP +: 3];
          s_d.trfc = nw[C5_TRFC +: 8];
          s_d.odt = nw[C5_ODT +: 2];
          s_d.ds = nw[C5_DS];
          s_d.trcd = nw[C5_TRCD +: 3];
          s_d.tras = nw[C5_TRAS +: 5];
        end
        OFS_SDR: begin
          s_d.sd_ref = nw[SD_REF];
          s_d.sd_trp = nw[SD_TRP];
          s_d.sd_trfc = nw[SD_TRFC +: 3];
          s_d.sd_cas = nw[SD_CAS];
          s_d.sd_bank = nw[SD_BANK +: 3];
          s_d.sd_col = nw[SD_COL +: 2];
          if (s_q.wstrb[2] && nw[SD_CMD +: 3] != CMD_NONE) begin
            s_d.sd_cmd = nw[SD_CMD +: 3];
          end
          s_d.sd_page = nw[SD_PAGE];
          s_d.sd_rld = nw[SD_RLD +: 15];
        end
        OFS_PWR: begin
          if (s_q.pw_mode == PM_NONE) begin
            s_d.pw_ce = nw[PW_CE];
          end
          if (mobile_support) begin
            s_d.pw_txsr = nw[PW_TXSR +: 4];
            s_d.pw_mode = nw[PW_PMODE +: 3];
            s_d.pw_ds = nw[PW_DS +: 2];
            s_d.pw_tcsr = nw[PW_TCSR +: 2];
            s_d.pw_partial_refresh_area = nw[PW_PARTIAL_REFRESH_AREA +: 3];
          end
        end
        OFS_MUX: begin
          s_d.mux = nw[MX_CTL +: 8];
        end
        default: begin
          s_d.bresp = RESP_SLVERR;
        end
      endcase
    end
    s_d.awready = !s_d.aw_have && !s_d.bvalid;
    s_d.wready = !s_d.w_have && !s_d.bvalid;
    // read channel: one read outstanding, data registered with the answer
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = stcr_word(s_q, s_axi_araddr, mobile_support);
      s_d.rresp = stcr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    s_d.arready = !s_d.rvalid;
    // derived timing values
    s_d.rd_dly = {2'b00, s_d.rd_lo} + {s_d.rd_hi, 2'b00};
    s_d.o_trp = {1'b0, s_d.trp} + ADD_TWO;
    s_d.o_trfc = {1'b0, s_d.trfc} + ADD_THREE;
    s_d.o_trcd = {1'b0, s_d.trcd} + ADD_TWO;
    s_d.o_tras = {1'b0, s_d.tras} + {2'b00, ADD_TWO};
    s_d.o_sd_trfc_hi = (mobile_support && s_d.sd_trp) ? 2'h2 : 2'h0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.rd_lo <= RD_LO_RST;
      s_q.rd_dly <= {2'b00, RD_LO_RST};
      s_q.o_trp <= ADD_TWO;
      s_q.o_trfc <= ADD_THREE;
      s_q.o_trcd <= ADD_TWO;
      s_q.o_tras <= {2'b00, ADD_TWO};
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
  assign clock_phase_step = s_q.ph_step;
  assign clock_phase_inc = s_q.ph_inc;
  assign lane_delay_update = s_q.ln_upd;
  assign lane_delay_inc = s_q.ln_inc;
  assign byte_delay_reset = s_q.bd_rst;
  assign read_delay_cycles = s_q.rd_dly;
  assign ctrl_extra_latency = s_q.reg_mem;
  assign trtp_cycles = {1'b1, s_q.trtp};
  assign trp_cycles = s_q.o_trp;
  assign trfc_cycles = s_q.o_trfc;
  assign trcd_cycles = s_q.o_trcd;
  assign tras_cycles = s_q.o_tras;
  assign twr_field = s_q.twr;
  assign cas_field = s_q.tcl;
  assign eight_banks = s_q.b8;
  assign dqs_gate_offset = s_q.dqs;
  assign odt_enable = |s_q.odt;
  assign odt_sel = s_q.odt;
  assign drive_strength_sel = s_q.ds;
  assign sdr_trp_cycles = {1'b1, s_q.sd_trp};
  assign sdr_trfc_cycles = {1'b0, s_q.o_sd_trfc_hi[1], s_q.sd_trfc} + 5'h03;
  assign sdr_cas_cycles = {1'b1, s_q.sd_cas};
  assign sdr_trcd_cycles = {1'b1, s_q.sd_cas};
  assign sdr_page_burst = s_q.sd_page;
  assign sdr_refresh_en = s_q.sd_ref;
  assign sdr_refresh_load = s_q.sd_rld;
  assign sdr_cmd = s_q.sd_cmd;
  assign sdr_cmd_valid = |s_q.sd_cmd;
  assign mem_cke = s_q.pw_ce;
  assign power_mode = s_q.pw_mode;
  assign partial_refresh_area = s_q.pw_partial_refresh_area;
  assign lane_mux_ctl = s_q.mux;

endmodule : stcr_regs

// ==== tb/stcr_sdram_model.sv ====
`timescale 1ns/1ns
module stcr_sdram_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slow,
  input wire logic sdr_cmd_valid,
  output logic sdr_cmd_done = 1'b0
);
  logic [3:0] wait_q = 4'h0;
  // the memory executes a pending command after a short or a long delay
  always @(posedge aclk) begin
    sdr_cmd_done <= 1'b0;
    if (!aresetn || !sdr_cmd_valid || sdr_cmd_done) begin
      wait_q <= 4'h0;
    end else if (wait_q == (slow ? 4'h9 : 4'h0)) begin
      sdr_cmd_done <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : stcr_sdram_model

// ==== tb/stcr_regs_properties.sv ====
`timescale 1ns/1ns
module stcr_regs_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic s_axi_bvalid,
  input wire logic mobile_support,
  input wire logic sdr_cmd_done,
  input wire logic clock_phase_step,
  input wire logic [11:0] lane_delay_update,
  input wire logic byte_delay_reset,
  input wire logic [3:0] read_delay_cycles,
  input wire logic [1:0] trtp_cycles,
  input wire logic [3:0] trp_cycles,
  input wire logic [8:0] trfc_cycles,
  input wire logic [3:0] trcd_cycles,
  input wire logic [5:0] tras_cycles,
  input wire logic odt_enable,
  input wire logic [1:0] odt_sel,
  input wire logic [1:0] sdr_trp_cycles,
  input wire logic [1:0] sdr_cas_cycles,
  input wire logic [1:0] sdr_trcd_cycles,
  input wire logic [2:0] sdr_cmd,
  input wire logic sdr_cmd_valid,
  input wire logic mem_cke,
  input wire logic [2:0] power_mode,
  input wire logic [2:0] partial_refresh_area
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst_rd; $rose(aresetn) |-> read_delay_cycles == 4'h1; endproperty
  a_rst_rd: assert property (p_rst_rd) else $error("read delay reset value");
  property p_step; clock_phase_step |=> !clock_phase_step; endproperty
  a_step: assert property (p_step) else $error("phase step not one pulse");
  property p_lane; lane_delay_update != 12'h0 || byte_delay_reset
    |=> lane_delay_update == 12'h0 && !byte_delay_reset; endproperty
  a_lane: assert property (p_lane) else $error("lane pulse too long");
  property p_trp; trp_cycles inside {[4'h2:4'h9]} && trfc_cycles >= 9'h003; endproperty
  a_trp: assert property (p_trp) else $error("trp or trfc offset");
  property p_trcd; trcd_cycles inside {[4'h2:4'h9]} && tras_cycles >= 6'h02; endproperty
  a_trcd: assert property (p_trcd) else $error("trcd or tras offset");
  property p_trtp; trtp_cycles inside {2'h2, 2'h3}; endproperty
  a_trtp: assert property (p_trtp) else $error("trtp offset");
  property p_odt; odt_enable == (odt_sel != 2'h0); endproperty
  a_odt: assert property (p_odt) else $error("termination enable");
  property p_cas; sdr_cas_cycles == sdr_trcd_cycles && sdr_trp_cycles inside {2'h2, 2'h3};
  endproperty
  a_cas: assert property (p_cas) else $error("sdr cas or trp");
  property p_cmd_hold; sdr_cmd_valid && !sdr_cmd_done |=> sdr_cmd_valid; endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command lost");
  property p_cmd_clr; sdr_cmd_valid && sdr_cmd_done && clk_en
    |=> !sdr_cmd_valid || $rose(s_axi_bvalid); endproperty
  a_cmd_clr: assert property (p_cmd_clr) else $error("command not cleared");
  property p_cke; power_mode != 3'h0 |=> $stable(mem_cke); endproperty
  a_cke: assert property (p_cke) else $error("cke changed in power mode");
  property p_ro; !mobile_support
    |=> $stable(power_mode) && $stable(partial_refresh_area); endproperty
  a_ro: assert property (p_ro) else $error("mobile field written");
endmodule : stcr_regs_checker
bind stcr_regs stcr_regs_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_bvalid(s_axi_bvalid),
  .mobile_support(mobile_support), .sdr_cmd_done(sdr_cmd_done),
  .clock_phase_step(clock_phase_step), .lane_delay_update(lane_delay_update),
  .byte_delay_reset(byte_delay_reset), .read_delay_cycles(read_delay_cycles),
  .trtp_cycles(trtp_cycles), .trp_cycles(trp_cycles), .trfc_cycles(trfc_cycles),
  .trcd_cycles(trcd_cycles), .tras_cycles(tras_cycles), .odt_enable(odt_enable),
  .odt_sel(odt_sel), .sdr_trp_cycles(sdr_trp_cycles), .sdr_cas_cycles(sdr_cas_cycles),
  .sdr_trcd_cycles(sdr_trcd_cycles), .sdr_cmd(sdr_cmd), .sdr_cmd_valid(sdr_cmd_valid),
  .mem_cke(mem_cke), .power_mode(power_mode), .partial_refresh_area(partial_refresh_area)
);

// ==== tb/test_sdram_timing_config_regs.sv ====
`timescale 1ns/1ns
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
  $display("Error %0t: got %0h expected %0h", $time, a, e); end end
module test_sdram_timing_config_regs;
  import stcr_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, mobile_support = 1'b0, slow = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1, sdr_cmd_done;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, dqs_gate_offset, lane_mux_ctl;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf, read_delay_cycles, trp_cycles, trcd_cycles;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, trtp_cycles, cas_field, odt_sel;
  logic [1:0] sdr_trp_cycles, sdr_cas_cycles, sdr_trcd_cycles;
  logic clock_phase_step, clock_phase_inc, byte_delay_reset, ctrl_extra_latency;
  logic eight_banks, odt_enable, drive_strength_sel, sdr_page_burst, sdr_refresh_en;
  logic sdr_cmd_valid, mem_cke;
  logic [11:0] lane_delay_update, lane_delay_inc, lane_seen = 12'h000;
  logic [8:0] trfc_cycles;
  logic [5:0] tras_cycles;
  logic [4:0] twr_field, sdr_trfc_cycles;
  logic [14:0] sdr_refresh_load;
  logic [2:0] sdr_cmd, power_mode, partial_refresh_area, last_cmd = 3'h0;
  logic [2:0] cmds [4] = '{3'h2, 3'h4, 3'h6, 3'h7};
  logic [2:0] areas [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  int miscompares = 0, cmp_count = 0, n_step = 0, n_brst = 0;
  stcr_regs dut (.*);
  stcr_sdram_model u_mem (.*);
  always #4 aclk = ~aclk;
  always @(posedge aclk) begin
    if (clock_phase_step) n_step <= n_step + 1;
    if (byte_delay_reset) n_brst <= n_brst + 1;
    if (sdr_cmd_valid) last_cmd <= sdr_cmd;
    lane_seen <= lane_seen | lane_delay_update;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  task automatic guard(input int n);
    if (n >= 40) begin
      miscompares++;
      give_verdict();
    end
  endtask : guard
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 40);
    guard(n);
    `CHK(s_axi_bresp, er)
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 40);
    guard(n);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
  endtask : rd
  task automatic wait_cmd();
    int n;
    n = 0;
    while (sdr_cmd_valid && n < 40) begin
      @(posedge aclk);
      n++;
    end
    guard(n);
  endtask : wait_cmd
  function automatic logic [31:0] pw(logic ce, logic [2:0] m, logic [2:0] a);
    return {1'b0, ce, 11'h0, m, 13'h0, a};
  endfunction : pw
  task automatic t_defaults();
    logic [31:0] d;
    logic [1:0] r;
    `CHK(read_delay_cycles, 4'h1)
    rd(OFS_CFG3, d, r);
    `CHK(d[17:16], RD_LO_RST)
    `CHK({trp_cycles, trcd_cycles, tras_cycles}, {4'h2, 4'h2, 6'h02})
    rd(8'h40, d, r);
    `CHK({r, d}, {RESP_SLVERR, 32'h0})
    wr(8'h40, 32'hffffffff, RESP_SLVERR);
    wr(OFS_MUX, 32'hffffffff, RESP_OKAY);
    rd(OFS_MUX, d, r);
    `CHK({d[18:12], lane_mux_ctl}, {MUX_DWTH_VAL, MUX_BEID_VAL, 8'hff})
    $display("test defaults done");
  endtask : t_defaults
  task automatic t_ddr();
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CFG5, {4'hf, 2'h3, 8'hff, i[1:0], 1'b1, 4'hf, 3'h7, 3'h7, 5'h1f}, RESP_OKAY);
      `CHK({odt_enable, odt_sel}, {i != 0, i[1:0]})
    end
    rd(OFS_CFG5, d, r);
    `CHK({d[31], d[27:26], d[14:11], d[7:5]}, 10'h0)
    `CHK({trp_cycles, trcd_cycles}, {4'h9, 4'h9})
    `CHK({trfc_cycles, tras_cycles}, {9'h102, 6'h21})
    `CHK(drive_strength_sel, 1'b1)
    rd(OFS_CFG3, d, r);
    `CHK({d[28], d[22:18]}, 6'h3f)
    wr(OFS_CFG3, {4'h0, 5'h15, 5'h0, 2'h3, 16'h0}, RESP_OKAY);
    `CHK({trp_cycles, trfc_cycles, twr_field}, {4'h8, 9'h0e3, 5'h15})
    wr(OFS_CFG4, {8'h0, 2'h3, 1'b1, 7'h7f, 1'b1, 2'h3, 2'h2, 1'b1, 8'h5a}, RESP_OKAY);
    `CHK(read_delay_cycles, 4'hf)
    `CHK({ctrl_extra_latency, trtp_cycles}, {1'b1, 2'h3})
    rd(OFS_CFG4, d, r);
    `CHK({d[20:14], d[12:11]}, 9'h0)
    `CHK({cas_field, eight_banks, dqs_gate_offset}, {2'h2, 1'b1, 8'h5a})
    $display("test ddr timing done");
  endtask : t_ddr
  task automatic t_pulses();
    logic [31:0] d;
    logic [1:0] r;
    wr(OFS_CFG3, {3'h7, 13'h0, 8'ha5, 8'hff}, RESP_OKAY);
    wr(OFS_CFG4, {4'h9, 4'hf, 2'h3, 22'h0}, RESP_OKAY);
    `CHK({n_step, n_brst}, {32'd1, 32'd1})
    `CHK({clock_phase_inc, lane_seen, lane_delay_inc}, {1'b1, 12'hfff, 12'h9a5})
    `CHK(read_delay_cycles, 4'hc)
    rd(OFS_CFG3, d, r);
    `CHK(d[31:29], 3'h0)
    wr(OFS_CFG3, {3'h1, 29'h0}, RESP_OKAY);
    `CHK({n_step, clock_phase_inc}, {32'd2, 1'b0})
    $display("test delay pulses done");
  endtask : t_pulses
  task automatic t_sdr();
    logic [31:0] d;
    logic [1:0] r;
    slow <= 1'b1;
    wr(OFS_SDR, {2'h3, 3'h7, 1'b1, 5'h0, 3'h6, 1'b1, 2'h3, 15'h1234}, RESP_OKAY);
    `CHK({sdr_trp_cycles, sdr_cas_cycles, sdr_trcd_cycles}, 6'h3f)
    `CHK({sdr_page_burst, sdr_trfc_cycles}, {1'b1, 5'h0a})
    `CHK({sdr_refresh_en, sdr_refresh_load}, {1'b1, 15'h1234})
    `CHK({sdr_cmd_valid, sdr_cmd}, 4'he)
    wait_cmd();
    rd(OFS_SDR, d, r);
    `CHK({d[20:18], d[16:15]}, {3'h0, 1'b0, D64_VAL})
    mobile_support <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK(sdr_trfc_cycles, 5'h12)
    slow <= 1'b0;
    foreach (cmds[k]) begin
      wr(OFS_SDR, {11'h0, cmds[k], 18'h0}, RESP_OKAY);
      wait_cmd();
      `CHK({sdr_cmd_valid, last_cmd}, {1'b0, cmds[k]})
    end
    $display("test sdr commands done");
  endtask : t_sdr
  task automatic t_power();
    logic [31:0] d;
    logic [1:0] r;
    mobile_support <= 1'b0;
    repeat (2) @(posedge aclk);
    wr(OFS_PWR, pw(1'b1, 3'h1, 3'h6), RESP_OKAY);
    `CHK({power_mode, partial_refresh_area, mem_cke}, 7'h01)
    mobile_support <= 1'b1;
    repeat (2) @(posedge aclk);
    wr(OFS_PWR, pw(1'b0, 3'h1, 3'h0), RESP_OKAY);
    `CHK({power_mode, mem_cke}, 4'h2)
    wr(OFS_PWR, pw(1'b1, 3'h2, 3'h0), RESP_OKAY);
    `CHK({power_mode, mem_cke}, 4'h4)
    foreach (areas[k]) begin
      wr(OFS_PWR, pw(1'b0, 3'h5, areas[k]), RESP_OKAY);
      `CHK({power_mode, partial_refresh_area}, {3'h5, areas[k]})
    end
    wr(OFS_PWR, pw(1'b1, 3'h0, 3'h0), RESP_OKAY);
    `CHK({power_mode, mem_cke}, 4'h0)
    wr(OFS_PWR, pw(1'b1, 3'h0, 3'h0), RESP_OKAY);
    rd(OFS_PWR, d, r);
    `CHK({mem_cke, d[31:30]}, 3'h7)
    $display("test power saving done");
  endtask : t_power
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_defaults();
    t_ddr();
    t_pulses();
    t_sdr();
    t_power();
    give_verdict();
  end
endmodule : test_sdram_timing_config_regs
